/* inc/tmr2_pkg.sv */
package tmr2_pkg;
    // Register indices on the plain register port
    localparam logic [2:0] ADDR_CONTROL = 3'h0;
    localparam logic [2:0] ADDR_COUNT_LOW = 3'h1;
    localparam logic [2:0] ADDR_COUNT_HIGH = 3'h2;
    localparam logic [2:0] ADDR_RELOAD_LOW = 3'h3;
    localparam logic [2:0] ADDR_RELOAD_HIGH = 3'h4;
    localparam logic [2:0] ADDR_MODE = 3'h5;
    // Control register bit positions
    localparam int BIT_OVF = 7;
    localparam int BIT_EXT_EVENT = 6;
    localparam int BIT_RX_BAUD = 5;
    localparam int BIT_TX_BAUD = 4;
    localparam int BIT_EXT_TRIG = 3;
    localparam int BIT_RUN = 2;
    localparam int BIT_COUNTER_SEL = 1;
    localparam int BIT_CAPTURE_SEL = 0;
    // Mode register bit positions
    localparam int BIT_DOWN_EN = 0;
    localparam int BIT_SIX_CLK = 1;
    // Reset values and count limit
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [7:0] MODE_RESET = 8'h00;
    localparam logic [15:0] COUNT_MAX = 16'hffff;
    // Oscillator periods per tick
    localparam logic [3:0] DIV_TIMER_SIX = 4'h6;
    localparam logic [3:0] DIV_TIMER_TWELVE = 4'hc;
    localparam logic [3:0] DIV_BAUD_SIX = 4'h1;
    localparam logic [3:0] DIV_BAUD_TWELVE = 4'h2;
    // Operating modes
    typedef enum logic [1:0] {
        TMR2_MODE_RELOAD = 2'b00,
        TMR2_MODE_CAPTURE = 2'b01,
        TMR2_MODE_BAUD = 2'b10
    } tmr2_mode_t;
endpackage

/* rtl/tmr2_timer.sv */
`timescale 1ns/1ps
// Notes on behaviour
// - Sixteen-bit counter of low and high byte; counter_select picks timer or events.
// - Timer ticks once per machine cycle: every 6 or 12 oscillator periods.
// - Counter operation advances on each falling edge of the count input.
// - Three modes: capture, auto-reload up or down, baud-rate generation.
// - Counting only while run_control is 1; clearing it holds the count.
// - Capture mode without trigger: plain timer, overflow sets ovf_flag.
// - Capture with trigger: trigger fall copies count to reload, sets ext_event_flag.
// - Capture mode never reloads; counting continues after a capture.
// - Both flags share one interrupt request, ext_event_flag only while down_count_enable is 0; software reads both.
// - down_count_enable resets to 0, so auto-reload counts up.
// - Up auto-reload: overflow past ffff sets ovf_flag and loads reload value.
// - Up auto-reload with trigger: trigger fall reloads and sets ext_event_flag.
// - Down enabled, trigger high: count up, overflow sets flag and reloads.
// - Down enabled, trigger low: count down; at reload value set flag, load ffff.
// - Down enabled: ext_event_flag toggles each wrap and requests no interrupt.
// - ovf_flag is bit 7, sticky, never set when a baud select is 1.
// - rx_baud_select routes this counter's overflows to the receive clock.
// - tx_baud_select routes this counter's overflows to the transmit clock.
// - ext_trigger_enable gates trigger events in every mode, serial port clocking included.
// - Baud mode ticks every 1 or 2 oscillator periods, reloads on rollover.
// - Baud mode trigger fall sets ext_event_flag without any reload.
module tmr2_timer (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // Register port
    input wire logic [2:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [7:0] rdata_out,
    // Pins
    input wire logic count_input_pin_in,
    input wire logic trigger_pin_in,
    // Serial port and interrupt side
    input wire logic timer1_ovf_in,
    output logic rx_baud_tick_out,
    output logic tx_baud_tick_out,
    output logic irq_out
);
    // Complete state of the block
    typedef struct packed {
        logic [1:0] cnt_sync;
        logic [1:0] trg_sync;
        logic cnt_prev;
        logic trg_prev;
        logic [3:0] div;
        logic [15:0] count;
        logic [15:0] reload;
        logic [7:0] control;
        logic [7:0] mode;
        logic [7:0] rdata;
        logic wrap_pulse;
    } tmr2_state_t;

    tmr2_state_t st;
    tmr2_state_t next_st;

    tmr2_pkg::tmr2_mode_t op_mode;
    logic baud_sel;
    logic down_en;
    logic six_clk;
    logic [3:0] div_len;
    logic cnt_fall;
    logic trg_fall;
    logic trg_level;
    logic tick;
    logic wrap;
    logic trig_ok;
    logic [7:0] read_mux;

    // Mode decode
    always_comb begin
        baud_sel = st.control[tmr2_pkg::BIT_RX_BAUD] | st.control[tmr2_pkg::BIT_TX_BAUD];
        down_en = st.mode[tmr2_pkg::BIT_DOWN_EN];
        six_clk = st.mode[tmr2_pkg::BIT_SIX_CLK];
        if (baud_sel) begin
            op_mode = tmr2_pkg::TMR2_MODE_BAUD;
        end else if (st.control[tmr2_pkg::BIT_CAPTURE_SEL]) begin
            op_mode = tmr2_pkg::TMR2_MODE_CAPTURE;
        end else begin
            op_mode = tmr2_pkg::TMR2_MODE_RELOAD;
        end
    end

    // Pin edges from the second synchroniser stage
    assign cnt_fall = st.cnt_prev & ~st.cnt_sync[1];
    assign trg_fall = st.trg_prev & ~st.trg_sync[1];
    assign trg_level = st.trg_sync[1];

    // Tick source: divided clock or count pin falling edge
    always_comb begin
        if (op_mode == tmr2_pkg::TMR2_MODE_BAUD) begin
            div_len = six_clk ? tmr2_pkg::DIV_BAUD_SIX : tmr2_pkg::DIV_BAUD_TWELVE;
        end else begin
            div_len = six_clk ? tmr2_pkg::DIV_TIMER_SIX : tmr2_pkg::DIV_TIMER_TWELVE;
        end
        if (!st.control[tmr2_pkg::BIT_RUN]) begin
            tick = 1'b0;
        end else if (st.control[tmr2_pkg::BIT_COUNTER_SEL]) begin
            tick = cnt_fall;
        end else begin
            tick = (st.div >= div_len - 4'h1);
        end
    end

    // Wrap condition: overflow, or underflow when counting down
    always_comb begin
        if (op_mode == tmr2_pkg::TMR2_MODE_RELOAD && down_en && !trg_level) begin
            wrap = tick && (st.count == st.reload);
        end else begin
            wrap = tick && (st.count == tmr2_pkg::COUNT_MAX);
        end
        trig_ok = st.control[tmr2_pkg::BIT_EXT_TRIG] && trg_fall;
    end

    // Read data selection
    always_comb begin
        unique case (addr_in)
            tmr2_pkg::ADDR_CONTROL: read_mux = st.control;
            tmr2_pkg::ADDR_COUNT_LOW: read_mux = st.count[7:0];
            tmr2_pkg::ADDR_COUNT_HIGH: read_mux = st.count[15:8];
            tmr2_pkg::ADDR_RELOAD_LOW: read_mux = st.reload[7:0];
            tmr2_pkg::ADDR_RELOAD_HIGH: read_mux = st.reload[15:8];
            tmr2_pkg::ADDR_MODE: read_mux = st.mode;
            default: read_mux = 8'h00;
        endcase
    end

    // Next state
    always_comb begin
        next_st = st;
        next_st.cnt_sync = {st.cnt_sync[0], count_input_pin_in};
        next_st.trg_sync = {st.trg_sync[0], trigger_pin_in};
        next_st.cnt_prev = st.cnt_sync[1];
        next_st.trg_prev = st.trg_sync[1];
        next_st.rdata = rd_in ? read_mux : 8'h00;
        next_st.wrap_pulse = 1'b0;
        // Machine-cycle divider runs freely
        if (st.div >= div_len - 4'h1) begin
            next_st.div = 4'h0;
        end else begin
            next_st.div = st.div + 4'h1;
        end
        // Software writes; hardware events below take priority
        if (wr_in) begin
            unique case (addr_in)
                tmr2_pkg::ADDR_CONTROL: next_st.control = wdata_in;
                tmr2_pkg::ADDR_COUNT_LOW: next_st.count[7:0] = wdata_in;
                tmr2_pkg::ADDR_COUNT_HIGH: next_st.count[15:8] = wdata_in;
                tmr2_pkg::ADDR_RELOAD_LOW: next_st.reload[7:0] = wdata_in;
                tmr2_pkg::ADDR_RELOAD_HIGH: next_st.reload[15:8] = wdata_in;
                tmr2_pkg::ADDR_MODE: next_st.mode = wdata_in & 8'h03;
                default: ;
            endcase
        end
        // Counting per mode
        if (tick) begin
            unique case (op_mode)
                tmr2_pkg::TMR2_MODE_CAPTURE: begin
                    next_st.count = st.count + 16'h0001;
                end
                tmr2_pkg::TMR2_MODE_BAUD: begin
                    next_st.count = wrap ? st.reload : st.count + 16'h0001;
                end
                tmr2_pkg::TMR2_MODE_RELOAD: begin
                    if (down_en && !trg_level) begin
                        next_st.count = wrap ? tmr2_pkg::COUNT_MAX : st.count - 16'h0001;
                    end else begin
                        next_st.count = wrap ? st.reload : st.count + 16'h0001;
                    end
                end
                default: ;
            endcase
        end
        if (wrap) begin
            next_st.wrap_pulse = 1'b1;
            if (!baud_sel) begin
                next_st.control[tmr2_pkg::BIT_OVF] = 1'b1;
            end
            if (op_mode == tmr2_pkg::TMR2_MODE_RELOAD && down_en) begin
                next_st.control[tmr2_pkg::BIT_EXT_EVENT] = ~st.control[tmr2_pkg::BIT_EXT_EVENT];
            end
        end
        // Trigger pin events
        if (trig_ok) begin
            unique case (op_mode)
                tmr2_pkg::TMR2_MODE_CAPTURE: begin
                    next_st.reload = st.count;
                    next_st.control[tmr2_pkg::BIT_EXT_EVENT] = 1'b1;
                end
                tmr2_pkg::TMR2_MODE_RELOAD: begin
                    if (!down_en) begin
                        next_st.count = st.reload;
                        next_st.control[tmr2_pkg::BIT_EXT_EVENT] = 1'b1;
                    end
                end
                tmr2_pkg::TMR2_MODE_BAUD: begin
                    next_st.control[tmr2_pkg::BIT_EXT_EVENT] = 1'b1;
                end
                default: ;
            endcase
        end
    end

    // State register
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            st <= '0;
            st.control <= tmr2_pkg::CONTROL_RESET;
            st.mode <= tmr2_pkg::MODE_RESET;
        end else begin
            st <= next_st;
        end
    end

    // Outputs
    assign rdata_out = st.rdata;
    assign irq_out = st.control[tmr2_pkg::BIT_OVF] |
        (st.control[tmr2_pkg::BIT_EXT_EVENT] & ~st.mode[tmr2_pkg::BIT_DOWN_EN]);
    assign rx_baud_tick_out = st.control[tmr2_pkg::BIT_RX_BAUD] ?
        st.wrap_pulse : timer1_ovf_in;
    assign tx_baud_tick_out = st.control[tmr2_pkg::BIT_TX_BAUD] ?
        st.wrap_pulse : timer1_ovf_in;

    // Checks
    run_hold_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (!st.control[tmr2_pkg::BIT_RUN] && !wr_in && !trig_ok) |=> $stable(st.count))
        else $error("count moved while stopped");
    ovf_set_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (wrap && !baud_sel) |=> st.control[tmr2_pkg::BIT_OVF])
        else $error("overflow flag not set");
    ovf_baud_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (baud_sel && !st.control[tmr2_pkg::BIT_OVF] && !wr_in)
        |=> !st.control[tmr2_pkg::BIT_OVF])
        else $error("overflow flag set in baud mode");
    reload_up_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (wrap && op_mode == tmr2_pkg::TMR2_MODE_RELOAD && !(down_en && !trg_level))
        |=> st.count == $past(st.reload))
        else $error("reload missing on overflow");
    down_wrap_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (wrap && op_mode == tmr2_pkg::TMR2_MODE_RELOAD && down_en && !trg_level && !wr_in)
        |=> st.count == tmr2_pkg::COUNT_MAX)
        else $error("underflow load wrong");
    capture_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (trig_ok && op_mode == tmr2_pkg::TMR2_MODE_CAPTURE && !wr_in)
        |=> st.reload == $past(st.count) && st.control[tmr2_pkg::BIT_EXT_EVENT])
        else $error("capture failed");
    toggle_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (wrap && op_mode == tmr2_pkg::TMR2_MODE_RELOAD && down_en && !wr_in)
        |=> st.control[tmr2_pkg::BIT_EXT_EVENT] != $past(st.control[tmr2_pkg::BIT_EXT_EVENT]))
        else $error("extra bit did not toggle");
    baud_route_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (wrap && st.control[tmr2_pkg::BIT_TX_BAUD]) ##1 st.control[tmr2_pkg::BIT_TX_BAUD]
        |-> tx_baud_tick_out)
        else $error("transmit tick missing");

    // Read data port
    rdata_idle_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        !rd_in |=> rdata_out == 8'h00)
        else $error("read data not cleared");
    rdata_ctrl_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (rd_in && addr_in == tmr2_pkg::ADDR_CONTROL)
        |=> rdata_out == $past(st.control))
        else $error("control read wrong");
    rdata_low_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (rd_in && addr_in == tmr2_pkg::ADDR_COUNT_LOW)
        |=> rdata_out == $past(st.count[7:0]))
        else $error("count low read wrong");
    rdata_high_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (rd_in && addr_in == tmr2_pkg::ADDR_COUNT_HIGH)
        |=> rdata_out == $past(st.count[15:8]))
        else $error("count high read wrong");
    mode_mask_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (wr_in && addr_in == tmr2_pkg::ADDR_MODE)
        |=> st.mode[7:2] == 6'h00)
        else $error("mode register kept unused bits");

    // Counting steps per mode
    stop_no_wrap_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        !st.control[tmr2_pkg::BIT_RUN] |-> !wrap)
        else $error("wrap while stopped");
    capture_step_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (tick && op_mode == tmr2_pkg::TMR2_MODE_CAPTURE)
        |=> st.count == $past(st.count) + 16'h0001)
        else $error("capture mode step wrong");
    up_step_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (tick && op_mode == tmr2_pkg::TMR2_MODE_RELOAD && !(down_en && !trg_level)
        && !wrap && !trig_ok)
        |=> st.count == $past(st.count) + 16'h0001)
        else $error("up count step wrong");
    down_step_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (tick && op_mode == tmr2_pkg::TMR2_MODE_RELOAD && down_en && !trg_level
        && !wrap)
        |=> st.count == $past(st.count) - 16'h0001)
        else $error("down count step wrong");
    baud_reload_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (wrap && op_mode == tmr2_pkg::TMR2_MODE_BAUD)
        |=> st.count == $past(st.reload))
        else $error("baud reload missing");
    timer_gap_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (tick && !st.control[tmr2_pkg::BIT_COUNTER_SEL]
        && op_mode != tmr2_pkg::TMR2_MODE_BAUD && !wr_in)
        |=> !tick)
        else $error("timer ticks too close");

    // Pin edges reach the logic
    sequence cnt_fall_s;
        st.cnt_sync[1] ##1 !st.cnt_sync[1];
    endsequence
    sequence trg_fall_s;
        st.trg_sync[1] ##1 !st.trg_sync[1];
    endsequence
    cnt_edge_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (cnt_fall_s ##0 (st.control[tmr2_pkg::BIT_RUN] && st.control[tmr2_pkg::BIT_COUNTER_SEL]))
        |-> tick)
        else $error("count pin edge lost");
    trg_edge_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (trg_fall_s ##0 st.control[tmr2_pkg::BIT_EXT_TRIG])
        |-> trig_ok)
        else $error("trigger pin edge lost");

    // Trigger pin events
    trig_reload_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (trig_ok && op_mode == tmr2_pkg::TMR2_MODE_RELOAD && !down_en)
        |=> st.count == $past(st.reload) && st.control[tmr2_pkg::BIT_EXT_EVENT])
        else $error("trigger reload failed");
    baud_trig_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (trig_ok && op_mode == tmr2_pkg::TMR2_MODE_BAUD)
        |=> st.control[tmr2_pkg::BIT_EXT_EVENT])
        else $error("baud trigger flag missing");
    trig_off_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (trg_fall && !st.control[tmr2_pkg::BIT_EXT_TRIG] && !wr_in && !wrap)
        |=> $stable(st.control[tmr2_pkg::BIT_EXT_EVENT]) && $stable(st.reload))
        else $error("disabled trigger acted");
    down_trig_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (trig_ok && op_mode == tmr2_pkg::TMR2_MODE_RELOAD && down_en && !wrap
        && !wr_in)
        |=> $stable(st.control[tmr2_pkg::BIT_EXT_EVENT]))
        else $error("trigger acted in down mode");

    // Flags and outputs
    ovf_sticky_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (st.control[tmr2_pkg::BIT_OVF] && !(wr_in && addr_in == tmr2_pkg::ADDR_CONTROL))
        |=> st.control[tmr2_pkg::BIT_OVF])
        else $error("overflow flag lost");
    ext_sticky_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (st.control[tmr2_pkg::BIT_EXT_EVENT] && !(wr_in && addr_in == tmr2_pkg::ADDR_CONTROL)
        && !(wrap && down_en && op_mode == tmr2_pkg::TMR2_MODE_RELOAD))
        |=> st.control[tmr2_pkg::BIT_EXT_EVENT])
        else $error("event flag lost");
    irq_ovf_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        st.control[tmr2_pkg::BIT_OVF] |-> irq_out)
        else $error("overflow request missing");
    irq_down_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (st.mode[tmr2_pkg::BIT_DOWN_EN] && !st.control[tmr2_pkg::BIT_OVF])
        |-> !irq_out)
        else $error("request from extra count bit");
    rx_route_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (wrap && st.control[tmr2_pkg::BIT_RX_BAUD]) ##1 st.control[tmr2_pkg::BIT_RX_BAUD]
        |-> rx_baud_tick_out)
        else $error("receive tick missing");
    rx_pass_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        !st.control[tmr2_pkg::BIT_RX_BAUD] |-> rx_baud_tick_out == timer1_ovf_in)
        else $error("receive clock not from other timer");
    tx_pass_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        !st.control[tmr2_pkg::BIT_TX_BAUD] |-> tx_baud_tick_out == timer1_ovf_in)
        else $error("transmit clock not from other timer");
    pulse_idle_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        !wrap |=> !st.wrap_pulse)
        else $error("wrap pulse without wrap");
endmodule // tmr2_timer

/* tb/testbench.sv */
`timescale 1ns/1ps
module testbench;
    logic clk_in, rst_n_in, wr_in, rd_in, cnt_pin, trg_pin, t1_ovf, rx_tick, tx_tick, irq, rd_q;
    logic [2:0] addr_in;
    logic [7:0] wdata_in, rdata_out;
    logic [7:0] exp_q[$];
    int n_mismatch, samples_checked, n_tx, n_rx;
    logic [31:0] seed;

    // Device under test
    tmr2_timer dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .addr_in(addr_in),
        .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
        .count_input_pin_in(cnt_pin), .trigger_pin_in(trg_pin), .timer1_ovf_in(t1_ovf),
        .rx_baud_tick_out(rx_tick), .tx_baud_tick_out(tx_tick), .irq_out(irq));

    // Clock at 200 MHz
    initial begin
        clk_in = 1'b0;
        forever #2.5 clk_in = ~clk_in;
    end

    // Pseudo-random source
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic stop_test;
        $display("checks=%0d mismatches=%0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    // Read data stands only in the cycle after the strobe
    always @(posedge clk_in) begin
        if (rd_q === 1'b1) chk({8'h00, rdata_out}, {8'h00, exp_q.pop_front()});
        rd_q <= rd_in;
    end

    // Register port master
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk_in);
        addr_in <= a;
        wdata_in <= d;
        wr_in <= 1'b1;
        @(posedge clk_in);
        wr_in <= 1'b0;
    endtask

    task automatic rd(input logic [2:0] a, input logic [7:0] e);
        @(posedge clk_in);
        addr_in <= a;
        rd_in <= 1'b1;
        exp_q.push_back(e);
        @(posedge clk_in);
        rd_in <= 1'b0;
    endtask

    task automatic rd16(input logic [2:0] a, input logic [15:0] e);
        rd(a, e[7:0]);
        rd(a + 3'h1, e[15:8]);
        repeat (2) @(posedge clk_in);
    endtask

    task automatic wr16(input logic [2:0] a, input logic [15:0] d);
        wr(a, d[7:0]);
        wr(a + 3'h1, d[15:8]);
    endtask

    // One falling edge on a pin, sel 1 picks the trigger pin
    task automatic fall(input bit sel);
        @(posedge clk_in);
        if (sel) trg_pin <= 1'b0; else cnt_pin <= 1'b0;
        repeat (5) @(posedge clk_in);
        if (sel) trg_pin <= 1'b1; else cnt_pin <= 1'b1;
        repeat (6) @(posedge clk_in);
    endtask

    task automatic done(input string name);
        repeat (3) @(posedge clk_in);
        $display("test %s finished", name);
    endtask

    // Watchdog
    initial begin
        #(20000 * 5);
        n_mismatch++;
        stop_test();
    end

    // Main sequence
    initial begin
        {wr_in, rd_in, t1_ovf, rst_n_in} = 4'h0;
        {cnt_pin, trg_pin} = 2'b11;
        addr_in = 3'h0;
        wdata_in = 8'h00;
        seed = 32'h60da;
        repeat (3) @(posedge clk_in);
        rst_n_in <= 1'b1;
        for (int a = 0; a < 6; a++) rd(a[2:0], 8'h00);
        wr(3'h6, 8'hff);
        rd(3'h6, 8'h00);
        for (int i = 0; i < 4; i++) begin
            seed = lfsr(seed);
            wr16(tmr2_pkg::ADDR_RELOAD_LOW, seed[15:0]);
            rd16(tmr2_pkg::ADDR_RELOAD_LOW, seed[15:0]);
        end
        done("reset_regs");
        // Event counting, capture mode, overflow rolls to zero
        wr(tmr2_pkg::ADDR_CONTROL, 8'h07);
        wr16(tmr2_pkg::ADDR_COUNT_LOW, 16'hfffe);
        fall(0);
        fall(0);
        rd16(tmr2_pkg::ADDR_COUNT_LOW, 16'h0000);
        rd(tmr2_pkg::ADDR_CONTROL, 8'h87);
        chk({15'h0, irq}, 16'h1);
        wr(tmr2_pkg::ADDR_CONTROL, 8'h03);
        fall(0);
        rd16(tmr2_pkg::ADDR_COUNT_LOW, 16'h0000);
        chk({15'h0, irq}, 16'h0);
        done("count_stop");
        // Capture on trigger, counting goes on
        wr(tmr2_pkg::ADDR_CONTROL, 8'h0f);
        wr16(tmr2_pkg::ADDR_COUNT_LOW, 16'h1234);
        fall(1);
        rd16(tmr2_pkg::ADDR_RELOAD_LOW, 16'h1234);
        rd(tmr2_pkg::ADDR_CONTROL, 8'h4f);
        chk({15'h0, irq}, 16'h1);
        fall(0);
        rd16(tmr2_pkg::ADDR_COUNT_LOW, 16'h1235);
        done("capture");
        // Auto-reload upward, by overflow and by trigger
        wr(tmr2_pkg::ADDR_CONTROL, 8'h06);
        wr16(tmr2_pkg::ADDR_RELOAD_LOW, 16'habcd);
        wr16(tmr2_pkg::ADDR_COUNT_LOW, 16'hffff);
        fall(0);
        rd16(tmr2_pkg::ADDR_COUNT_LOW, 16'habcd);
        rd(tmr2_pkg::ADDR_CONTROL, 8'h86);
        wr(tmr2_pkg::ADDR_CONTROL, 8'h0e);
        wr16(tmr2_pkg::ADDR_COUNT_LOW, 16'h0010);
        fall(1);
        rd16(tmr2_pkg::ADDR_COUNT_LOW, 16'habcd);
        rd(tmr2_pkg::ADDR_CONTROL, 8'h4e);
        done("reload_up");
        // Up/down counting with the trigger pin as direction
        wr(tmr2_pkg::ADDR_MODE, 8'h01);
        wr(tmr2_pkg::ADDR_CONTROL, 8'h06);
        wr16(tmr2_pkg::ADDR_COUNT_LOW, 16'habce);
        trg_pin <= 1'b0;
        fall(0);
        rd16(tmr2_pkg::ADDR_COUNT_LOW, 16'habcd);
        fall(0);
        rd16(tmr2_pkg::ADDR_COUNT_LOW, 16'hffff);
        rd(tmr2_pkg::ADDR_CONTROL, 8'hc6);
        wr(tmr2_pkg::ADDR_CONTROL, 8'h46);
        repeat (2) @(posedge clk_in);
        chk({15'h0, irq}, 16'h0);
        trg_pin <= 1'b1;
        fall(0);
        rd16(tmr2_pkg::ADDR_COUNT_LOW, 16'habcd);
        rd(tmr2_pkg::ADDR_CONTROL, 8'h86);
        done("up_down");
        // Timer ticks per machine cycle, 12-clock then 6-clock
        for (int m = 0; m < 2; m++) begin
            wr(tmr2_pkg::ADDR_MODE, m[0] ? 8'h02 : 8'h00);
            wr16(tmr2_pkg::ADDR_COUNT_LOW, 16'h0000);
            wr(tmr2_pkg::ADDR_CONTROL, 8'h05);
            repeat (118) @(posedge clk_in);
            wr(tmr2_pkg::ADDR_CONTROL, 8'h01);
            rd16(tmr2_pkg::ADDR_COUNT_LOW, m[0] ? 16'd20 : 16'd10);
        end
        done("timer_rate");
        // Baud generation: wrap every tick, no overflow flag
        for (int m = 0; m < 2; m++) begin
            wr(tmr2_pkg::ADDR_MODE, m[0] ? 8'h02 : 8'h00);
            wr16(tmr2_pkg::ADDR_RELOAD_LOW, 16'hffff);
            wr16(tmr2_pkg::ADDR_COUNT_LOW, 16'hffff);
            wr(tmr2_pkg::ADDR_CONTROL, m[0] ? 8'h24 : 8'h34);
            repeat (8) @(posedge clk_in);
            n_tx = 0;
            n_rx = 0;
            repeat (40) begin
                @(posedge clk_in);
                n_tx += tx_tick;
                n_rx += rx_tick;
            end
            chk(n_tx[15:0], m[0] ? 16'd0 : 16'd20);
            chk(n_rx[15:0], m[0] ? 16'd40 : 16'd20);
            rd(tmr2_pkg::ADDR_CONTROL, m[0] ? 8'h24 : 8'h34);
            wr(tmr2_pkg::ADDR_CONTROL, m[0] ? 8'h2c : 8'h3c);
            fall(1);
            rd(tmr2_pkg::ADDR_CONTROL, m[0] ? 8'h6c : 8'h7c);
            wr(tmr2_pkg::ADDR_CONTROL, 8'h00);
        end
        // Serial clocks follow the other timer when not selected
        @(posedge clk_in);
        t1_ovf <= 1'b1;
        @(posedge clk_in);
        #1;
        chk({14'h0, rx_tick, tx_tick}, 16'h3);
        @(posedge clk_in);
        t1_ovf <= 1'b0;
        done("baud");
        stop_test();
    end
endmodule // testbench
